// file: rtl/dsxe_consts.svh
// opcode encodings, program counter width and stack depth for the subtract and table-move execution block
`ifndef DSXE_CONSTS_SVH
`define DSXE_CONSTS_SVH
`define DSXE_OP_MASK 16'hFF00
`define DSXE_OP_CONDITIONAL_SUBTRACT_OP 16'h6400
`define DSXE_OP_SUBTRACT_HIGH_OP 16'h6200
`define DSXE_OP_UNSIGNED_SUBTRACT_OP 16'h6300
`define DSXE_OP_TABLE_READ_OP 16'h6700
`define DSXE_OP_TABLE_WRITE_OP 16'h7D00
`define DSXE_OP_XOR 16'h7800
`define DSXE_PC_W 12
`define DSXE_STACK_DEPTH 4
`endif

// file: rtl/dsxe_exec.sv
// execution logic for conditional/high/unsigned subtract, xor and table read/write
// Functional notes
// RULE_01: conditional subtract is a one-cycle division step
// RULE_02: no forwarding after conditional subtract
// RULE_03: subtract-high subtracts from upper accumulator half
// RULE_04: table read copies program word, three cycles
// RULE_05: table write copies data word to program
// RULE_06: table write is prefetch plus three cycles
// RULE_07: prefetch strobes memory, fetches opcode
// RULE_08: cycle one strobes, drives next address, ignores data
// RULE_09: cycle one pushes program counter
// RULE_10: cycle one loads pc from accumulator low twelve
// RULE_11: table write cycle two asserts write strobe
// RULE_12: table write cycle two drives data word
// RULE_13: end of cycle two pops stack into pc
// RULE_14: cycle three strobes memory, prefetches opcode
// RULE_15: outside decode cannot tell writes at 0-7
// RULE_16: unsigned subtract zero-extends the data word
// RULE_17: xor touches low half only, one cycle
// RULE_18: table read cycle two stores returned word
`include "dsxe_consts.svh"
module dsxe_exec #(
  parameter int PC_W = `DSXE_PC_W,
  parameter int DEPTH = `DSXE_STACK_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [6:0] dma,
  input wire logic [15:0] dmem_rdata,
  // program bus
  input wire logic [15:0] pbus_rdata,
  output dsxe_pkg::dsxe_pbus_t pbus,
  // data memory write
  output dsxe_pkg::dsxe_dmem_t dmem,
  // core state
  output logic [31:0] acc,
  output logic [PC_W-1:0] pc,
  output logic busy,
  output logic [15:0] fetched_op
);
  dsxe_pkg::dsxe_state_t state;
  logic is_table_write_op;
  logic [6:0] tbl_dma;
  logic [15:0] tbl_word;
  logic [PC_W-1:0] stack_top [DEPTH];
  logic [31:0] next_acc;
  logic [32:0] diff;
  logic [31:0] sub_op;

  function automatic logic is_op(input logic [15:0] w, input logic [15:0] op);
    return (w & `DSXE_OP_MASK) == op;
  endfunction : is_op

  // shifted trial difference of the conditional subtract step
  function automatic logic [31:0] conditional_subtract_op_diff(input logic [31:0] a, input logic [15:0] d);
    return a - {1'b0, d, 15'h0};
  endfunction : conditional_subtract_op_diff

  wire logic issue = instr_valid && !busy;
  wire logic tbl_issue = issue && (is_op(instr, `DSXE_OP_TABLE_READ_OP) || is_op(instr, `DSXE_OP_TABLE_WRITE_OP));

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic decode for the single-cycle ops
  always_comb begin
    next_acc = acc;
    sub_op = 32'h0;
    diff = 33'h0;
    if (issue) begin
      if (is_op(instr, `DSXE_OP_CONDITIONAL_SUBTRACT_OP)) begin
        // one step of restoring division; result not forwarded to next op
        sub_op = {1'b0, dmem_rdata, 15'h0}; // RULE_01
        diff = {1'b0, acc} - {1'b0, sub_op};
        if (!diff[31]) begin
          next_acc = {diff[30:0], 1'b1}; // RULE_01 RULE_02
        end else begin
          next_acc = {acc[30:0], 1'b0};
        end
      end else if (is_op(instr, `DSXE_OP_SUBTRACT_HIGH_OP)) begin
        next_acc = {acc[31:16] - dmem_rdata, acc[15:0]}; // RULE_03
      end else if (is_op(instr, `DSXE_OP_UNSIGNED_SUBTRACT_OP)) begin
        next_acc = acc - {16'h0, dmem_rdata}; // RULE_16
      end else if (is_op(instr, `DSXE_OP_XOR)) begin
        next_acc = {acc[31:16], acc[15:0] ^ dmem_rdata}; // RULE_17
      end
    end
  end

  // accumulator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 32'h0;
    end else begin
      acc <= next_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table transfer sequencer; busy holds issue off for three cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dsxe_pkg::DSXE_IDLE;
      is_table_write_op <= 1'b0;
      tbl_dma <= 7'h0;
      tbl_word <= 16'h0;
    end else begin
      case (state)
        dsxe_pkg::DSXE_IDLE: begin
          if (tbl_issue) begin
            state <= dsxe_pkg::DSXE_C1; // RULE_04 RULE_06
            is_table_write_op <= is_op(instr, `DSXE_OP_TABLE_WRITE_OP);
            tbl_dma <= dma;
            tbl_word <= dmem_rdata;
          end
        end
        dsxe_pkg::DSXE_C1: state <= dsxe_pkg::DSXE_C2;
        dsxe_pkg::DSXE_C2: state <= dsxe_pkg::DSXE_C3;
        dsxe_pkg::DSXE_C3: state <= dsxe_pkg::DSXE_IDLE;
        default: state <= dsxe_pkg::DSXE_IDLE;
      endcase
    end
  end

  assign busy = (state != dsxe_pkg::DSXE_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // program counter and hardware stack
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        stack_top[i] <= '0;
      end
    end else if (state == dsxe_pkg::DSXE_C1) begin
      // push next address, then jump to the table address
      stack_top[0] <= pc; // RULE_09
      for (int i = 1; i < DEPTH; i++) begin
        stack_top[i] <= stack_top[i-1];
      end
      pc <= acc[PC_W-1:0]; // RULE_10
    end else if (state == dsxe_pkg::DSXE_C2) begin
      pc <= stack_top[0]; // RULE_13
      for (int i = 0; i < DEPTH - 1; i++) begin
        stack_top[i] <= stack_top[i+1];
      end
    end else if (issue) begin
      pc <= pc + PC_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program bus drive; table writes look like port writes to outside decode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pbus <= '{addr: '0, wdata: 16'h0, wdata_oe: 1'b0, strobe_n: 1'b1, write_n: 1'b1};
    end else begin
      pbus.wdata_oe <= 1'b0;
      pbus.write_n <= 1'b1;
      pbus.strobe_n <= 1'b1;
      if (tbl_issue) begin
        // cycle one: strobe with next address, data ignored
        pbus.strobe_n <= 1'b0; // RULE_08
        pbus.addr <= pc;
      end else if (state == dsxe_pkg::DSXE_C1) begin
        pbus.addr <= acc[PC_W-1:0];
        if (is_table_write_op) begin
          pbus.write_n <= 1'b0; // RULE_11 RULE_15
          pbus.wdata <= tbl_word; // RULE_05 RULE_12
          pbus.wdata_oe <= 1'b1;
        end else begin
          pbus.strobe_n <= 1'b0; // RULE_04
        end
      end else if (state == dsxe_pkg::DSXE_C2) begin
        pbus.strobe_n <= 1'b0; // RULE_14
        pbus.addr <= stack_top[0];
      end else if (!busy) begin
        pbus.strobe_n <= 1'b0; // RULE_07
        pbus.addr <= pc;
      end
    end
  end

  // opcode latch on prefetch slots only; cycle one and two bus words are no opcode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetched_op <= 16'h0;
    end else if (!pbus.strobe_n && (state == dsxe_pkg::DSXE_IDLE || state == dsxe_pkg::DSXE_C3)) begin // RULE_08
      fetched_op <= pbus_rdata; // RULE_07 RULE_14
    end
  end

  // data memory write-back of the table read word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dmem <= '{addr: 7'h0, wdata: 16'h0, we: 1'b0};
    end else begin
      dmem.we <= (state == dsxe_pkg::DSXE_C2) && !is_table_write_op; // RULE_18
      dmem.addr <= tbl_dma;
      dmem.wdata <= pbus_rdata; // RULE_18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and prefetch checks; rst_n in an antecedent skips the release edge
  seq_three_a: assert property ( // RULE_04
    @(posedge core_clk) disable iff (!rst_n)
    tbl_issue |=> busy [*3] ##1 !busy)
    else $error("table op not three cycles");
  acc_hold_a: assert property ( // RULE_06
    @(posedge core_clk) disable iff (!rst_n)
    busy |=> acc == $past(acc))
    else $error("acc moved during table op");
  idle_prefetch_a: assert property ( // RULE_07
    @(posedge core_clk) disable iff (!rst_n)
    (rst_n && !busy && !tbl_issue) |=> (!pbus.strobe_n && pbus.write_n))
    else $error("no prefetch strobe");
  c1_strobe_a: assert property ( // RULE_08
    @(posedge core_clk) disable iff (!rst_n)
    tbl_issue |=> (!pbus.strobe_n && pbus.write_n))
    else $error("cycle one no strobe");
  c1_ignore_a: assert property ( // RULE_08
    @(posedge core_clk) disable iff (!rst_n)
    state == dsxe_pkg::DSXE_C1 |=> fetched_op == $past(fetched_op))
    else $error("cycle one data taken");

  // program counter and stack
  stack_push_a: assert property ( // RULE_09
    @(posedge core_clk) disable iff (!rst_n)
    state == dsxe_pkg::DSXE_C1 |=> stack_top[0] == $past(pc))
    else $error("pc not pushed");
  pc_load_a: assert property ( // RULE_10
    @(posedge core_clk) disable iff (!rst_n)
    state == dsxe_pkg::DSXE_C1 |=> pc == $past(acc[PC_W-1:0]))
    else $error("pc not loaded");
  pc_restore_a: assert property ( // RULE_13
    @(posedge core_clk) disable iff (!rst_n)
    state == dsxe_pkg::DSXE_C1 |=> ##1 pc == $past(pc, 2))
    else $error("pc not restored");

  // program bus in cycles two and three
  table_write_op_write_a: assert property ( // RULE_11
    @(posedge core_clk) disable iff (!rst_n)
    (state == dsxe_pkg::DSXE_C1 && is_table_write_op) |=> (!pbus.write_n && pbus.wdata_oe))
    else $error("no write strobe");
  table_write_op_data_a: assert property ( // RULE_12
    @(posedge core_clk) disable iff (!rst_n)
    (state == dsxe_pkg::DSXE_C1 && is_table_write_op) |=> pbus.wdata == $past(tbl_word))
    else $error("bad write data");
  c2_addr_a: assert property ( // RULE_11
    @(posedge core_clk) disable iff (!rst_n)
    state == dsxe_pkg::DSXE_C1 |=> pbus.addr == $past(acc[PC_W-1:0]))
    else $error("cycle two address wrong");
  table_read_op_no_write_a: assert property ( // RULE_04
    @(posedge core_clk) disable iff (!rst_n)
    (state == dsxe_pkg::DSXE_C1 && !is_table_write_op) |=> (!pbus.strobe_n && pbus.write_n && !pbus.wdata_oe))
    else $error("table read drives a write");
  c3_strobe_a: assert property ( // RULE_14
    @(posedge core_clk) disable iff (!rst_n)
    state == dsxe_pkg::DSXE_C2 |=> !pbus.strobe_n)
    else $error("cycle three no strobe");
  c3_addr_a: assert property ( // RULE_14
    @(posedge core_clk) disable iff (!rst_n)
    state == dsxe_pkg::DSXE_C2 |=> pbus.addr == pc)
    else $error("cycle three address wrong");

  // data memory write-back
  table_read_op_store_a: assert property ( // RULE_18
    @(posedge core_clk) disable iff (!rst_n)
    (state == dsxe_pkg::DSXE_C2 && !is_table_write_op) |=> (dmem.we && dmem.wdata == $past(pbus_rdata)))
    else $error("no store");
  dmem_pulse_a: assert property ( // RULE_18
    @(posedge core_clk) disable iff (!rst_n)
    dmem.we |=> !dmem.we)
    else $error("store longer than one cycle");
  table_write_op_no_store_a: assert property ( // RULE_05
    @(posedge core_clk) disable iff (!rst_n)
    (state == dsxe_pkg::DSXE_C2 && is_table_write_op) |=> !dmem.we)
    else $error("table write stored to data memory");

  // single-cycle arithmetic
  conditional_subtract_op_pass_a: assert property ( // RULE_01
    @(posedge core_clk) disable iff (!rst_n)
    (issue && is_op(instr, `DSXE_OP_CONDITIONAL_SUBTRACT_OP) && conditional_subtract_op_diff(acc, dmem_rdata) < 32'h80000000)
    |=> acc == ((conditional_subtract_op_diff($past(acc), $past(dmem_rdata)) << 1) | 32'h00000001))
    else $error("division step pass wrong");
  conditional_subtract_op_fail_a: assert property ( // RULE_01
    @(posedge core_clk) disable iff (!rst_n)
    (issue && is_op(instr, `DSXE_OP_CONDITIONAL_SUBTRACT_OP) && conditional_subtract_op_diff(acc, dmem_rdata) >= 32'h80000000)
    |=> acc == {$past(acc[30:0]), 1'b0})
    else $error("division step shift wrong");
  subtract_high_op_high_a: assert property ( // RULE_03
    @(posedge core_clk) disable iff (!rst_n)
    (issue && is_op(instr, `DSXE_OP_SUBTRACT_HIGH_OP)) |=> acc[31:16] == $past(acc[31:16]) - $past(dmem_rdata))
    else $error("subtract_high_op high wrong");
  subtract_high_op_low_a: assert property ( // RULE_03
    @(posedge core_clk) disable iff (!rst_n)
    (issue && is_op(instr, `DSXE_OP_SUBTRACT_HIGH_OP)) |=> acc[15:0] == $past(acc[15:0]))
    else $error("subtract_high_op low changed");
  unsigned_subtract_op_val_a: assert property ( // RULE_16
    @(posedge core_clk) disable iff (!rst_n)
    (issue && is_op(instr, `DSXE_OP_UNSIGNED_SUBTRACT_OP)) |=> acc == $past(acc) - {16'h0, $past(dmem_rdata)})
    else $error("unsigned_subtract_op bad");
  xor_low_a: assert property ( // RULE_17
    @(posedge core_clk) disable iff (!rst_n)
    (issue && is_op(instr, `DSXE_OP_XOR)) |=> acc[15:0] == ($past(acc[15:0]) ^ $past(dmem_rdata)))
    else $error("xor low wrong");
  xor_high_a: assert property ( // RULE_17
    @(posedge core_clk) disable iff (!rst_n)
    (issue && is_op(instr, `DSXE_OP_XOR)) |=> acc[31:16] == $past(acc[31:16]))
    else $error("xor high changed");
endmodule : dsxe_exec

// file: rtl/dsxe_pkg.sv
// types shared by the subtract and table-move execution block
package dsxe_pkg;
  typedef enum logic [1:0] {
    DSXE_IDLE = 2'h0,
    DSXE_C1 = 2'h1,
    DSXE_C2 = 2'h3,
    DSXE_C3 = 2'h2
  } dsxe_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wdata_oe;
    logic strobe_n;
    logic write_n;
  } dsxe_pbus_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] wdata;
    logic we;
  } dsxe_dmem_t;
endpackage : dsxe_pkg

// file: test/dsxe_prog_mem.sv
// external program memory model on the far side of the program bus
module dsxe_prog_mem (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // program bus
  input dsxe_pkg::dsxe_pbus_t pbus,
  output logic [15:0] pbus_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [4096];
  logic [15:0] last;
  ////////////////////////////////////////////////////////////
  // read path: unselected lines show a changing value, never a stale word
  assign pbus_rdata = !pbus.strobe_n ? mem[pbus.addr] : ~last;
  // writes land at any address, low ones included; reset fills a known pattern
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last <= 16'h0000;
      for (int i = 0; i < 4096; i++) begin
        mem[i] <= 16'(i) ^ 16'hA5C3;
      end
    end else begin
      last <= pbus_rdata;
      if (!pbus.write_n) begin
        mem[pbus.addr] <= pbus.wdata;
      end
    end
  end
endmodule : dsxe_prog_mem

// file: test/test_dsp_subtract_table_move_exec.sv
// self-checking bench for the subtract and table-move execution block
`include "dsxe_consts.svh"
module test_dsp_subtract_table_move_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst_n, instr_valid, busy;
  logic [15:0] instr, dmem_rdata, pbus_rdata, fetched_op, w;
  logic [6:0] dma;
  logic [31:0] acc, model_acc, r;
  logic [11:0] pc, pc1;
  dsxe_pkg::dsxe_pbus_t pbus;
  dsxe_pkg::dsxe_dmem_t dmem;
  int errors, check_count;
  logic [15:0] ops [4] = '{`DSXE_OP_CONDITIONAL_SUBTRACT_OP, `DSXE_OP_SUBTRACT_HIGH_OP, `DSXE_OP_UNSIGNED_SUBTRACT_OP, `DSXE_OP_XOR};
  dsxe_exec u_dsxe_exec (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .dma(dma), .dmem_rdata(dmem_rdata), .pbus_rdata(pbus_rdata), .pbus(pbus), .dmem(dmem), .acc(acc),
    .pc(pc), .busy(busy), .fetched_op(fetched_op));
  dsxe_prog_mem u_dsxe_prog_mem (.core_clk(core_clk), .rst_n(rst_n), .pbus(pbus), .pbus_rdata(pbus_rdata));
  ////////////////////////////////////////////////////////////
  // expected accumulator after one single-cycle op
  function automatic logic [31:0] nxt(input logic [15:0] op, input logic [31:0] a, input logic [15:0] d);
    logic [31:0] diff;
    diff = a - {1'b0, d, 15'h0000};
    case (op)
      `DSXE_OP_SUBTRACT_HIGH_OP: return a - {d, 16'h0000};
      `DSXE_OP_UNSIGNED_SUBTRACT_OP: return a - {16'h0000, d};
      `DSXE_OP_XOR: return {a[31:16], a[15:0] ^ d};
      `DSXE_OP_CONDITIONAL_SUBTRACT_OP: return diff[31] ? {a[30:0], 1'b0} : {diff[30:0], 1'b1};
      default: return a;
    endcase
  endfunction : nxt
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one request; returns one step after the edge that takes it
  task automatic issue(input logic [15:0] op, input logic [15:0] d, input logic [6:0] a);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= op | {9'h000, a};
    dma <= a;
    dmem_rdata <= d;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask : issue
  task automatic single(input logic [15:0] op, input logic [15:0] d, input logic [6:0] a);
    model_acc = nxt(op, model_acc, d);
    issue(op, d, a);
    check("acc", acc, model_acc);
    check("prefetch", pbus.strobe_n, 1'b0);
  endtask : single
  // table transfer walked cycle by cycle; target is the low twelve accumulator bits
  task automatic table_op(input logic wr, input logic [15:0] d, input logic [6:0] a, input logic [15:0] word);
    logic [11:0] tgt;
    tgt = model_acc[11:0];
    issue(wr ? `DSXE_OP_TABLE_WRITE_OP : `DSXE_OP_TABLE_READ_OP, d, a);
    check("busy c1", busy, 1'b1);
    check("strobe c1", pbus.strobe_n, 1'b0);
    pc1 = pc;
    @(posedge core_clk);
    #1;
    check("pc load", pc, tgt);
    check("addr c2", pbus.addr, tgt);
    if (wr) begin
      check("write c2", {pbus.write_n, pbus.wdata_oe}, 2'h1);
      check("wdata c2", pbus.wdata, d);
    end else begin
      check("strobe c2", pbus.strobe_n, 1'b0);
    end
    @(posedge core_clk);
    #1;
    check("strobe c3", pbus.strobe_n, 1'b0);
    check("pc pop", pc, pc1);
    check("addr c3", pbus.addr, pc1);
    check("dmem we", dmem.we, !wr);
    if (!wr) begin
      check("dmem word", {dmem.addr, dmem.wdata}, {a, word});
    end
    @(posedge core_clk);
    #1;
    check("busy end", busy, 1'b0);
    check("acc kept", acc, model_acc);
    check("prefetch op", fetched_op, u_dsxe_prog_mem.mem[pc1]);
  endtask : table_op
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // watchdog: the run needs well under ten thousand cycles
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
  // corner cases first, then a seeded random mix with table pairs
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    dma = 7'h00;
    dmem_rdata = 16'h0000;
    model_acc = 32'h00000000;
    errors = 0;
    check_count = 0;
    void'($urandom(13));
    repeat (20) @(posedge core_clk);
    check("reset acc", acc, 32'h00000000);
    check("reset strobe", pbus.strobe_n, 1'b1);
    check("reset busy", busy, 1'b0);
    rst_n <= 1'b1;
    single(`DSXE_OP_XOR, 16'hFFFF, 7'h7F);
    single(`DSXE_OP_SUBTRACT_HIGH_OP, 16'h8000, 7'h00);
    single(`DSXE_OP_UNSIGNED_SUBTRACT_OP, 16'hF003, 7'h3D);
    single(`DSXE_OP_CONDITIONAL_SUBTRACT_OP, 16'h0001, 7'h01);
    single(`DSXE_OP_CONDITIONAL_SUBTRACT_OP, 16'hFFFF, 7'h02);
    for (int i = 0; i < 80; i++) begin
      r = $urandom;
      if (r[2:0] == 3'h7) begin
        w = 16'($urandom);
        table_op(1'b1, w, r[14:8], 16'h0000);
        table_op(1'b0, 16'($urandom), r[22:16], w);
      end else begin
        single(ops[r[1:0]], 16'($urandom), r[14:8]);
      end
    end
    wrap_up();
  end
endmodule : test_dsp_subtract_table_move_exec
